/* design/txp_pkg.sv */
package txp_pkg;

	// Register word width
	localparam int unsigned REG_W = 16;

	// Register offsets on the management interface
	localparam logic [15:0] OFS_CTRL     = 16'hbb2c;
	localparam logic [15:0] OFS_X_TARGET = 16'hbb2d;
	localparam logic [15:0] OFS_Y_TARGET = 16'hbb2e;
	localparam logic [15:0] OFS_X_DRIVE  = 16'hbb2f;
	localparam logic [15:0] OFS_Y_DRIVE  = 16'hbb30;
	localparam logic [15:0] OFS_T_DRIVE  = 16'hbb31;

	// Control word field positions
	localparam int unsigned BIT_TOT_LOOP = 15;
	localparam int unsigned BIT_X_LOOP   = 14;
	localparam int unsigned BIT_Y_LOOP   = 13;
	localparam int unsigned BIT_OUT_EN   = 12;
	localparam logic [15:0] CTRL_MASK    = 16'hf000;

	// Reset values
	localparam logic [15:0] RST_CTRL     = 16'h0000;
	localparam logic [15:0] RST_TARGET   = 16'h0000;
	localparam logic [15:0] RST_DRIVE    = 16'h0000;
	localparam logic [15:0] RD_UNMAPPED  = 16'h0000;

	// Drive settling window
	localparam int unsigned CLK_KHZ      = 25000;
	localparam int unsigned SETTLE_MS    = 100;
	localparam int unsigned SETTLE_CYC   = SETTLE_MS * CLK_KHZ;

	// Management word access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} txp_mgmt_req_t;

endpackage : txp_pkg

/* design/txp_drive_reg.sv */
`timescale 1ns/1ps

module txp_drive_reg #(
	parameter int unsigned    W   = 16,
	parameter logic [W-1:0]   RST = '0
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	// Closed loop side
	input  wire logic         loop_en_in,
	input  wire logic         loop_upd_in,
	input  wire logic [W-1:0] loop_data_in,
	// Host side
	input  wire logic         host_wr_in,
	input  wire logic [W-1:0] host_data_in,
	// Results
	output logic      [W-1:0] value_out,
	output logic              refused_out,
	output logic              changed_out
);

	logic [W-1:0] value_r;
	logic [W-1:0] value_nxt;
	logic         refused_r;
	logic         changed_r;
	wire          host_take;
	wire          loop_take;

	// Host writes land only while the loop is off; the loop owns it otherwise
	assign host_take = host_wr_in && !loop_en_in;
	assign loop_take = loop_upd_in && loop_en_in;
	assign value_nxt = loop_take ? loop_data_in : (host_take ? host_data_in : value_r);

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			value_r   <= RST;
			refused_r <= 1'b0;
			changed_r <= 1'b0;
		end
		else
		begin
			value_r   <= value_nxt;
			refused_r <= host_wr_in && loop_en_in;
			changed_r <= value_nxt != value_r;
		end
	end

	assign value_out   = value_r;
	assign refused_out = refused_r;
	assign changed_out = changed_r;

	lock_hold_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(host_wr_in && loop_en_in && !loop_upd_in) |=> $stable(value_r))
		else $error("Drive changed by host while loop enabled");

	open_load_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(host_wr_in && !loop_en_in) |=> (value_r == $past(host_data_in)))
		else $error("Drive missed host write with loop disabled");

endmodule : txp_drive_reg

/* design/txp_regs.sv */
`timescale 1ns/1ps

// Function
// - Control bit 15 turns total output power closed loop on or off.
// - Control bits 14 and 13 turn X and Y polarisation loops on or off.
// - Control bit 12 gates the output shutter independent of everything else.
// - Bit 12 high opens the shutter, low closes it and blocks output.
// - Control bits 11 to 0 are reserved, read zero, do nothing.
// - X target is signed 16-bit, 0.01 dBm per count, X loop setpoint.
// - Y target is signed 16-bit, 0.01 dBm per count, Y loop setpoint.
// - X drive is unsigned 16-bit, resets to zero, drives X power monotonically.
// - X drive accepts host writes only while the X loop is disabled.
// - Y drive is unsigned 16-bit, resets to zero, drives Y power monotonically.
// - Y drive accepts host writes only while the Y loop is disabled.
// - Drive step small enough that one count moves power at most 0.1 dB.
// - Drive change reaches 90 percent of effect within 100 ms.
// - Total drive is unsigned 16-bit with reset value zero.
// - Total drive writable only with total loop disabled; power monotonic in it.
module txp_regs #(
	parameter int unsigned SETTLE_CYCLES = txp_pkg::SETTLE_CYC
) (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	// Management access
	input  wire txp_pkg::txp_mgmt_req_t mgmt_req_in,
	output logic                [15:0] mgmt_rdata_out,
	output logic                       mgmt_ack_out,
	output logic                       wr_refused_out,
	// Closed loop results
	input  wire logic           [15:0] loop_x_drive_in,
	input  wire logic                  loop_x_upd_in,
	input  wire logic           [15:0] loop_y_drive_in,
	input  wire logic                  loop_y_upd_in,
	input  wire logic           [15:0] loop_t_drive_in,
	input  wire logic                  loop_t_upd_in,
	// Loop controls and setpoints
	output logic                       tot_loop_en_out,
	output logic                       x_loop_en_out,
	output logic                       y_loop_en_out,
	output logic signed         [15:0] x_target_out,
	output logic signed         [15:0] y_target_out,
	// Actuator drives
	output logic                       shutter_open_out,
	output logic                [15:0] x_drive_out,
	output logic                [15:0] y_drive_out,
	output logic                [15:0] t_drive_out,
	output logic                       drive_settling_out
);

	localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);

	logic [15:0]      ctrl_r;
	logic [15:0]      xtgt_r;
	logic [15:0]      ytgt_r;
	logic [15:0]      rdata_r;
	logic [15:0]      rdata_nxt;
	logic             ack_r;
	logic             refused_r;
	logic [CNT_W-1:0] settle_r;
	logic [CNT_W-1:0] settle_nxt;
	logic             settling_r;
	logic [15:0]      xdrv;
	logic [15:0]      ydrv;
	logic [15:0]      tdrv;
	logic             xref;
	logic             yref;
	logic             tref;
	logic             xchg;
	logic             ychg;
	logic             tchg;

	// Address decode
	wire wr      = mgmt_req_in.wr;
	wire rd      = mgmt_req_in.rd;
	wire hit_c   = mgmt_req_in.addr == txp_pkg::OFS_CTRL;
	wire hit_xt  = mgmt_req_in.addr == txp_pkg::OFS_X_TARGET;
	wire hit_yt  = mgmt_req_in.addr == txp_pkg::OFS_Y_TARGET;
	wire hit_xd  = mgmt_req_in.addr == txp_pkg::OFS_X_DRIVE;
	wire hit_yd  = mgmt_req_in.addr == txp_pkg::OFS_Y_DRIVE;
	wire hit_td  = mgmt_req_in.addr == txp_pkg::OFS_T_DRIVE;
	wire wr_c    = wr && hit_c;
	wire wr_xt   = wr && hit_xt;
	wire wr_yt   = wr && hit_yt;
	wire wr_xd   = wr && hit_xd;
	wire wr_yd   = wr && hit_yd;
	wire wr_td   = wr && hit_td;

	// Loop enables straight from the control word
	wire tot_en  = ctrl_r[txp_pkg::BIT_TOT_LOOP];
	wire x_en    = ctrl_r[txp_pkg::BIT_X_LOOP];
	wire y_en    = ctrl_r[txp_pkg::BIT_Y_LOOP];

	// Read data selection, whole words only
	assign rdata_nxt = hit_c  ? ctrl_r :
	                   hit_xt ? xtgt_r :
	                   hit_yt ? ytgt_r :
	                   hit_xd ? xdrv   :
	                   hit_yd ? ydrv   :
	                   hit_td ? tdrv   : txp_pkg::RD_UNMAPPED;

	// Settling window restarts on every drive change
	assign settle_nxt = (xchg || ychg || tchg) ? CNT_W'(SETTLE_CYCLES) :
	                    (settle_r != '0) ? settle_r - CNT_W'(1) : settle_r;

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			ctrl_r <= txp_pkg::RST_CTRL;
		end
		else if (wr_c)
		begin
			ctrl_r <= mgmt_req_in.wdata & txp_pkg::CTRL_MASK;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			xtgt_r <= txp_pkg::RST_TARGET;
			ytgt_r <= txp_pkg::RST_TARGET;
		end
		else
		begin
			xtgt_r <= wr_xt ? mgmt_req_in.wdata : xtgt_r;
			ytgt_r <= wr_yt ? mgmt_req_in.wdata : ytgt_r;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			rdata_r   <= txp_pkg::RD_UNMAPPED;
			ack_r     <= 1'b0;
			refused_r <= 1'b0;
		end
		else
		begin
			rdata_r   <= rd ? rdata_nxt : rdata_r;
			ack_r     <= rd || wr;
			refused_r <= xref || yref || tref;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			settle_r   <= '0;
			settling_r <= 1'b0;
		end
		else
		begin
			settle_r   <= settle_nxt;
			settling_r <= settle_nxt != '0;
		end
	end

	// X polarisation drive, step size set by the actuator scaling
	txp_drive_reg #(
		.W   (txp_pkg::REG_W),
		.RST (txp_pkg::RST_DRIVE)
	) u_xdrv (
		.clk_in       (clk_in),
		.srst_in      (srst_in),
		.loop_en_in   (x_en),
		.loop_upd_in  (loop_x_upd_in),
		.loop_data_in (loop_x_drive_in),
		.host_wr_in   (wr_xd),
		.host_data_in (mgmt_req_in.wdata),
		.value_out    (xdrv),
		.refused_out  (xref),
		.changed_out  (xchg)
	);

	// Y polarisation drive
	txp_drive_reg #(
		.W   (txp_pkg::REG_W),
		.RST (txp_pkg::RST_DRIVE)
	) u_ydrv (
		.clk_in       (clk_in),
		.srst_in      (srst_in),
		.loop_en_in   (y_en),
		.loop_upd_in  (loop_y_upd_in),
		.loop_data_in (loop_y_drive_in),
		.host_wr_in   (wr_yd),
		.host_data_in (mgmt_req_in.wdata),
		.value_out    (ydrv),
		.refused_out  (yref),
		.changed_out  (ychg)
	);

	// Total post-multiplexer drive
	txp_drive_reg #(
		.W   (txp_pkg::REG_W),
		.RST (txp_pkg::RST_DRIVE)
	) u_tdrv (
		.clk_in       (clk_in),
		.srst_in      (srst_in),
		.loop_en_in   (tot_en),
		.loop_upd_in  (loop_t_upd_in),
		.loop_data_in (loop_t_drive_in),
		.host_wr_in   (wr_td),
		.host_data_in (mgmt_req_in.wdata),
		.value_out    (tdrv),
		.refused_out  (tref),
		.changed_out  (tchg)
	);

	// Outputs
	assign mgmt_rdata_out     = rdata_r;
	assign mgmt_ack_out       = ack_r;
	assign wr_refused_out     = refused_r;
	assign tot_loop_en_out    = ctrl_r[txp_pkg::BIT_TOT_LOOP];
	assign x_loop_en_out      = ctrl_r[txp_pkg::BIT_X_LOOP];
	assign y_loop_en_out      = ctrl_r[txp_pkg::BIT_Y_LOOP];
	assign shutter_open_out   = ctrl_r[txp_pkg::BIT_OUT_EN];
	assign x_target_out       = xtgt_r;
	assign y_target_out       = ytgt_r;
	assign x_drive_out        = xdrv;
	assign y_drive_out        = ydrv;
	assign t_drive_out        = tdrv;
	assign drive_settling_out = settling_r;

	// Checks
	shutter_follow_a : assert property (@(posedge clk_in) disable iff (srst_in)
		wr_c |=> (shutter_open_out == $past(mgmt_req_in.wdata[12])))
		else $error("Shutter state does not follow output enable");

	shutter_hold_a : assert property (@(posedge clk_in) disable iff (srst_in)
		!wr_c |=> $stable(shutter_open_out))
		else $error("Shutter moved without control write");

	tot_loop_a : assert property (@(posedge clk_in) disable iff (srst_in)
		wr_c |=> (tot_loop_en_out == $past(mgmt_req_in.wdata[15])))
		else $error("Total loop enable wrong");

	pol_loop_a : assert property (@(posedge clk_in) disable iff (srst_in)
		wr_c |=> (x_loop_en_out == $past(mgmt_req_in.wdata[14]))
		&& (y_loop_en_out == $past(mgmt_req_in.wdata[13])))
		else $error("Polarisation loop enable wrong");

	rsvd_zero_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(rd && hit_c) |=> (mgmt_rdata_out[11:0] == 12'h000))
		else $error("Reserved control bits read nonzero");

	xtarget_load_a : assert property (@(posedge clk_in) disable iff (srst_in)
		wr_xt |=> (x_target_out == $past(mgmt_req_in.wdata)))
		else $error("X target not loaded");

	ytarget_load_a : assert property (@(posedge clk_in) disable iff (srst_in)
		wr_yt |=> (y_target_out == $past(mgmt_req_in.wdata)))
		else $error("Y target not loaded");

	xdrive_lock_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_xd && x_loop_en_out && !loop_x_upd_in) |=> $stable(x_drive_out) ##1 wr_refused_out)
		else $error("X drive write not refused under loop");

	ydrive_lock_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_yd && y_loop_en_out && !loop_y_upd_in) |=> $stable(y_drive_out))
		else $error("Y drive write not refused under loop");

	tdrive_lock_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_td && tot_loop_en_out && !loop_t_upd_in) |=> $stable(t_drive_out))
		else $error("Total drive write not refused under loop");

	xdrive_load_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_xd && !x_loop_en_out) |=> (x_drive_out == $past(mgmt_req_in.wdata)))
		else $error("X drive not loaded");

	settle_flag_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(x_drive_out != $past(x_drive_out)) |-> ##[1:2] drive_settling_out)
		else $error("Settling flag missing after drive change");

	access_ack_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(rd || wr) |=> mgmt_ack_out)
		else $error("Access not acknowledged");

	ack_cause_a : assert property (@(posedge clk_in) disable iff (srst_in)
		mgmt_ack_out |-> $past(rd || wr))
		else $error("Acknowledge without access");

	ydrive_load_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_yd && !y_loop_en_out) |=> (y_drive_out == $past(mgmt_req_in.wdata)))
		else $error("Y drive not loaded");

	tdrive_load_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_td && !tot_loop_en_out) |=> (t_drive_out == $past(mgmt_req_in.wdata)))
		else $error("Total drive not loaded");

	refuse_cause_a : assert property (@(posedge clk_in) disable iff (srst_in)
		wr_refused_out |-> $past((wr_xd && x_en) || (wr_yd && y_en) || (wr_td && tot_en), 2))
		else $error("Refusal without locked drive write");

	unmapped_read_a : assert property (@(posedge clk_in) disable iff (srst_in)
		(rd && !(hit_c || hit_xt || hit_yt || hit_xd || hit_yd || hit_td))
		|=> (mgmt_rdata_out == txp_pkg::RD_UNMAPPED))
		else $error("Unmapped read returned nonzero");

endmodule : txp_regs

/* bench/txp_host_model.sv */
`timescale 1ns/1ps

module txp_host_model (
	// Clock
	input  wire logic                   clk_in,
	// Management access
	output txp_pkg::txp_mgmt_req_t      req_out,
	input  wire logic                   ack_in,
	input  wire logic            [15:0] rdata_in
);
	initial req_out = '0;

	// One whole word per request, offered for one taking edge only
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic k);
	begin
		@(negedge clk_in);
		req_out = {w, ~w, a, d};
		@(negedge clk_in);
		req_out = '0;
		q = rdata_in;
		k = ack_in;
	end
	endtask : xfer
endmodule : txp_host_model

/* bench/test_tx_optical_power_control_regs.sv */
`timescale 1ns/1ps

module test_tx_optical_power_control_regs;
	typedef struct {
		logic [15:0] a;
		logic [15:0] d;
		logic [15:0] e;
	} txp_row_t;

	logic                   clk_in  = 1'b0;
	logic                   srst_in = 1'b1;
	txp_pkg::txp_mgmt_req_t req;
	logic            [15:0] rdata, xd, yd, td, q;
	logic            [15:0] lx = 16'h0000, ly = 16'h0000, lt = 16'h0000;
	logic                   lux = 1'b0, luy = 1'b0, lut = 1'b0;
	logic signed     [15:0] xt, yt;
	logic                   ack, refd, tle, xle, yle, shut, setl, k;
	int                     err_total    = 0;
	int                     total_checks = 0;
	int                     cyc          = 0;
	txp_row_t               rows [7] = '{
		'{txp_pkg::OFS_X_TARGET, 16'h8000, 16'h8000},
		'{txp_pkg::OFS_Y_TARGET, 16'h7fff, 16'h7fff},
		'{txp_pkg::OFS_X_DRIVE,  16'hffff, 16'hffff},
		'{txp_pkg::OFS_Y_DRIVE,  16'h0001, 16'h0001},
		'{txp_pkg::OFS_T_DRIVE,  16'h1234, 16'h1234},
		'{txp_pkg::OFS_CTRL,     16'h1fff, 16'h1000},
		'{txp_pkg::OFS_CTRL,     16'hf000, 16'hf000}};

	always #20 clk_in = ~clk_in;

	txp_regs #(.SETTLE_CYCLES(8)) txp_regs_inst (
		.clk_in(clk_in), .srst_in(srst_in), .mgmt_req_in(req),
		.mgmt_rdata_out(rdata), .mgmt_ack_out(ack), .wr_refused_out(refd),
		.loop_x_drive_in(lx), .loop_x_upd_in(lux), .loop_y_drive_in(ly),
		.loop_y_upd_in(luy), .loop_t_drive_in(lt), .loop_t_upd_in(lut),
		.tot_loop_en_out(tle), .x_loop_en_out(xle), .y_loop_en_out(yle),
		.x_target_out(xt), .y_target_out(yt), .shutter_open_out(shut),
		.x_drive_out(xd), .y_drive_out(yd), .t_drive_out(td),
		.drive_settling_out(setl));

	txp_host_model txp_host_model_inst (
		.clk_in(clk_in), .req_out(req), .ack_in(ack), .rdata_in(rdata));

	// Output port that mirrors a register
	function automatic logic [15:0] port_val(input logic [15:0] a);
		case (a)
			txp_pkg::OFS_CTRL:     return {tle, xle, yle, shut, 12'h000};
			txp_pkg::OFS_X_TARGET: return xt;
			txp_pkg::OFS_Y_TARGET: return yt;
			txp_pkg::OFS_X_DRIVE:  return xd;
			txp_pkg::OFS_Y_DRIVE:  return yd;
			default:               return td;
		endcase
	endfunction : port_val

	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk16

	task automatic chk1(input logic g, input logic e);
		chk16({15'h0000, g}, {15'h0000, e});
	endtask : chk1

	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		txp_host_model_inst.xfer(w, a, d, q, k);
		chk1(k, 1'b1);
	endtask : acc

	task automatic pulse_loops(input logic [15:0] v);
		@(negedge clk_in);
		{lx, ly, lt, lux, luy, lut} = {v, v + 16'h0001, v + 16'h0002, 3'b111};
		@(negedge clk_in);
		{lux, luy, lut} = 3'b000;
	endtask : pulse_loops

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		srst_in = 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			acc(1'b0, rows[i].a, 16'h0000);
			chk16(q, 16'h0000);
		end
		chk1(shut, 1'b0);
		foreach (rows[i])
		begin
			acc(1'b1, rows[i].a, rows[i].d);
			chk16(port_val(rows[i].a), rows[i].e);
			acc(1'b0, rows[i].a, 16'h0000);
			chk16(q, rows[i].e);
		end
		for (int i = 2; i < 5; i++)
		begin
			acc(1'b1, rows[i].a, 16'h5555);
			@(negedge clk_in);
			chk1(refd, 1'b1);
			acc(1'b0, rows[i].a, 16'h0000);
			chk16(q, rows[i].e);
		end
		pulse_loops(16'h0abc);
		chk16(xd, 16'h0abc);
		chk16(yd, 16'h0abd);
		chk16(td, 16'h0abe);
		acc(1'b1, 16'hbb32, 16'hffff);
		acc(1'b0, 16'hbb32, 16'h0000);
		chk16(q, 16'h0000);
		acc(1'b1, txp_pkg::OFS_CTRL, 16'h1000);
		chk16({12'h000, tle, xle, yle, shut}, 16'h0001);
		pulse_loops(16'h0123);
		chk16(xd, 16'h0abc);
		chk16(yd, 16'h0abd);
		chk16(td, 16'h0abe);
		acc(1'b1, txp_pkg::OFS_X_DRIVE, 16'h0001);
		chk16(xd, 16'h0001);
		@(negedge clk_in);
		chk1(refd, 1'b0);
		chk1(setl, 1'b1);
		repeat (7) @(negedge clk_in);
		chk1(setl, 1'b1);
		@(negedge clk_in);
		chk1(setl, 1'b0);
		srst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		chk16(xd, 16'h0000);
		chk1(shut, 1'b0);
		chk1(setl, 1'b0);
		acc(1'b0, txp_pkg::OFS_CTRL, 16'h0000);
		chk16(q, 16'h0000);
		wrap_up();
	end
endmodule : test_tx_optical_power_control_regs
